// ===== src/cts_pkg.sv
/*
  Shared constants and types for the change timestamp and schedule link.
  Assumes a 50 MHz reference clock and a 64-bit system time from a master.
*/
package cts_pkg;
  localparam int          CLK_HZ         = 50000000;
  localparam int          TIME_W         = 64;
  localparam int          POINTS         = 16;
  localparam int          SLOTS          = 4;
  localparam int          WINDOW_US      = 500;
  localparam int          WINDOW_CYC     = (WINDOW_US * (CLK_HZ / 1000000));
  localparam int          SPREAD_S       = 2;
  localparam logic [63:0] SPREAD_TICKS   = 64'h0000_0000_7735_9400;
  localparam logic [63:0] TIME_STEP      = 64'h0000_0000_0000_0014;
  localparam logic [63:0] TIME_RESET     = 64'h0000_0000_0000_0000;
  typedef logic [TIME_W-1:0] time_t;
  typedef logic [POINTS-1:0] pts_t;
endpackage

// ===== src/cts_if.sv
/*
  Link between the module end and the controller end.
  Assumes both ends run on the same ref_clk.
*/
`timescale 1ns/1ps
interface cts_if;
  import cts_pkg::*;
  // Time master.
  logic  sync_valid;
  time_t sync_time;
  // Produced input reports, one broadcast for all consumers.
  logic  rpt_valid;
  pts_t  rpt_state;
  time_t rpt_stamp;
  // Configuration.
  logic  cfg_stamped;
  pts_t  cfg_change_en;
  // Scheduled output commands.
  logic  sch_valid;
  logic  [1:0] sch_slot;
  pts_t  sch_mask;
  pts_t  sch_value;
  time_t sch_time;
  logic  sch_ready;
  modport module_end (input sync_valid, sync_time, cfg_stamped,
    cfg_change_en, sch_valid, sch_slot, sch_mask, sch_value, sch_time,
    output rpt_valid, rpt_state, rpt_stamp, sch_ready);
  modport ctrl_end (output sync_valid, sync_time, cfg_stamped,
    cfg_change_en, sch_valid, sch_slot, sch_mask, sch_value, sch_time,
    input rpt_valid, rpt_state, rpt_stamp, sch_ready);
endinterface

// ===== src/cts_module_end.sv
/*
  Module end: input change stamping, unsolicited reports, scheduled outputs.
  Assumes pins are asynchronous and the controller keeps its own duties.
*/
`timescale 1ns/1ps
module cts_module_end
  import cts_pkg::*;
#(
  parameter int WIN_CYC = WINDOW_CYC
) (
  // Clock and reset.
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Link.
  cts_if.module_end          lnk,
  // User side pins.
  input  wire cts_pkg::pts_t in_pins,
  output      cts_pkg::pts_t out_pins,
  output      cts_pkg::time_t local_time
);
  import cts_pkg::*;

  // The window counter is 16 bits and must close after the first change.
  if (WIN_CYC < 2 || WIN_CYC > 65535) begin : g_bad_window
    $error("Window length out of range.");
  end
  // Slot numbers on the link are two bits wide.
  if (SLOTS < 1 || SLOTS > 4) begin : g_bad_slots
    $error("Slot count out of range.");
  end

  pts_t  s1, s2, s3, state;
  time_t stamp;
  logic  [15:0] win_cnt;
  logic  win_open;
  pts_t  slot_mask [SLOTS];
  pts_t  slot_val  [SLOTS];
  time_t slot_time [SLOTS];
  logic  [SLOTS-1:0] slot_arm;
  pts_t  chg;
  logic  fresh;
  pts_t  settled;
  pts_t  next_out_pins;
  logic  [SLOTS-1:0] due;
  logic  take;

  // Takes the masked bits from new_bits and the others from old_bits.
  function automatic pts_t merge_bits(input pts_t old_bits,
                                      input pts_t new_bits,
                                      input pts_t mask);
    merge_bits = (old_bits & ~mask) | (new_bits & mask);
  endfunction

  // An enabled point has changed once its settled level differs from its state.
  assign settled = ~(s2 ^ s3);
  assign chg     = (s2 ^ state) & settled & lnk.cfg_change_en;
  assign fresh   = |chg;
  assign take    = lnk.sch_valid && lnk.sch_ready;

  // Three stages; a level counts once stages two and three agree.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= in_pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Local time follows the master but never steps back.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      local_time <= TIME_RESET;
    end else if (lnk.sync_valid && lnk.sync_time > local_time) begin
      local_time <= lnk.sync_time;
    end else begin
      local_time <= local_time + TIME_STEP;
    end
  end

  // Debounced point state, tracking all points.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= merge_bits(state, s2, settled);
    end
  end

  // Changes inside the window reuse the open stamp.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      win_cnt  <= '0;
      win_open <= 1'b0;
      stamp    <= TIME_RESET;
    end else if (fresh && !win_open) begin
      win_cnt  <= 16'(WIN_CYC - 1);
      win_open <= 1'b1;
      stamp    <= local_time;
    end else if (win_open) begin
      win_cnt  <= win_cnt - 16'h0001;
      win_open <= (win_cnt > 16'h0001);
    end
  end

  // Unsolicited broadcast report with a single stamp.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.rpt_valid <= 1'b0;
      lnk.rpt_state <= '0;
      lnk.rpt_stamp <= TIME_RESET;
    end else begin
      lnk.rpt_valid <= fresh;
      if (fresh) begin
        lnk.rpt_state <= merge_bits(state, s2, chg);
        lnk.rpt_stamp <= !lnk.cfg_stamped ? TIME_RESET :
                         (win_open ? stamp : local_time);
      end
    end
  end

  // Ready rises at the first edge after reset; commands are taken from the next edge on.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.sch_ready <= 1'b0;
    end else begin
      lnk.sch_ready <= 1'b1;
    end
  end

  // A slot is due once local time has reached its scheduled time.
  always_comb begin
    due = '0;
    for (int i = 0; i < SLOTS; i++) begin
      due[i] = slot_arm[i] && (local_time >= slot_time[i]);
    end
  end

  // Every due slot applies its bits in slot order, so the highest due slot wins on shared bits.
  always_comb begin
    next_out_pins = out_pins;
    for (int i = 0; i < SLOTS; i++) begin
      if (due[i]) begin
        next_out_pins = merge_bits(next_out_pins, slot_val[i],
                                   slot_mask[i]);
      end
    end
  end

  // Outputs come straight from this register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_pins <= '0;
    end else begin
      out_pins <= next_out_pins;
    end
  end

  // Each accepted command overwrites the contents of its slot.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_mask[i] <= '0;
        slot_val[i]  <= '0;
        slot_time[i] <= TIME_RESET;
      end
    end else if (take) begin
      slot_mask[lnk.sch_slot] <= lnk.sch_mask;
      slot_val[lnk.sch_slot]  <= lnk.sch_value;
      slot_time[lnk.sch_slot] <= lnk.sch_time;
    end
  end

  // A slot disarms when it fires; a new command for it rearms it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_arm <= '0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        if (take && lnk.sch_slot == 2'(i)) begin
          slot_arm[i] <= 1'b1;
        end else if (due[i]) begin
          slot_arm[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== src/cts_ctrl_end.sv
/*
  Controller end: forwards master time, configuration and schedules.
  Assumes the user side gives one schedule request at a time.
*/
`timescale 1ns/1ps
module cts_ctrl_end
  import cts_pkg::*;
(
  // Clock and reset.
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // Link.
  cts_if.ctrl_end             lnk,
  // Time master.
  input  wire logic           master_valid,
  input  wire cts_pkg::time_t master_time,
  // Configuration.
  input  wire logic           want_stamped,
  input  wire logic  [3:0]    seq_point,
  // Schedule request.
  input  wire logic           req_valid,
  input  wire logic  [1:0]    req_slot,
  input  wire cts_pkg::pts_t  req_mask,
  input  wire cts_pkg::pts_t  req_value,
  input  wire cts_pkg::time_t req_time,
  output      logic           req_refused,
  // Reports seen.
  output      logic           got_valid,
  output      cts_pkg::pts_t  got_state,
  output      cts_pkg::time_t got_stamp
);
  import cts_pkg::*;

  time_t first_time;
  logic  have_first;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.sync_valid    <= 1'b0;
      lnk.sync_time     <= TIME_RESET;
      lnk.cfg_stamped   <= 1'b0;
      lnk.cfg_change_en <= '0;
    end else begin
      lnk.sync_valid    <= master_valid;
      lnk.sync_time     <= master_time;
      lnk.cfg_stamped   <= want_stamped;
      lnk.cfg_change_en <= POINTS'(1) << seq_point;
    end
  end

  // Schedules in one packet must stay within the spread of the first.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.sch_valid <= 1'b0;
      lnk.sch_slot  <= '0;
      lnk.sch_mask  <= '0;
      lnk.sch_value <= '0;
      lnk.sch_time  <= TIME_RESET;
      req_refused   <= 1'b0;
      first_time    <= TIME_RESET;
      have_first    <= 1'b0;
    end else begin
      req_refused <= 1'b0;
      if (lnk.sch_valid && lnk.sch_ready) begin
        lnk.sch_valid <= 1'b0;
      end
      if (!req_valid) begin
        have_first <= 1'b0;
      end else if (!lnk.sch_valid) begin
        if (have_first && (req_time > first_time + SPREAD_TICKS ||
            first_time > req_time + SPREAD_TICKS)) begin
          req_refused <= 1'b1;
        end else begin
          lnk.sch_valid <= 1'b1;
          lnk.sch_slot  <= req_slot;
          lnk.sch_mask  <= req_mask;
          lnk.sch_value <= req_value;
          lnk.sch_time  <= req_time;
          if (!have_first) begin
            first_time <= req_time;
            have_first <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      got_valid <= 1'b0;
      got_state <= '0;
      got_stamp <= TIME_RESET;
    end else begin
      got_valid <= lnk.rpt_valid;
      got_state <= lnk.rpt_state;
      got_stamp <= lnk.rpt_stamp;
    end
  end
endmodule

// ===== sim/cts_assertions.sv
/* Checks on the link signals.
   Assumes instantiation beside the link. */
`timescale 1ns/1ps
module cts_assertions
  import cts_pkg::*;
#(
  parameter int WIN = 25000
) (
  // Clock and reset.
  input wire logic           ref_clk,
  input wire logic           rst,
  // Link.
  input wire logic           rpt_valid,
  input wire cts_pkg::pts_t  rpt_state,
  input wire cts_pkg::time_t rpt_stamp,
  input wire logic           cfg_stamped,
  input wire cts_pkg::pts_t  cfg_change_en,
  input wire logic           sch_valid,
  input wire logic           sch_ready
);
  time_t last;
  int    age;
  logic  seen;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last <= '0;
      age  <= 0;
      seen <= 1'b0;
    end else begin
      if (age < WIN) age <= age + 1;
      if (rpt_valid && cfg_stamped) begin
        seen <= 1'b1;
        last <= rpt_stamp;
        if (rpt_stamp != last) age <= 1;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ready; $past(rst) && !rst |=> sch_ready; endproperty
  property p_gap; sch_valid && sch_ready |=> !sch_valid; endproperty
  property p_hold;
    !rpt_valid |-> $stable(rpt_state) && $stable(rpt_stamp);
  endproperty
  property p_zero; rpt_valid && !cfg_stamped |-> rpt_stamp == '0; endproperty
  property p_mono;
    rpt_valid && cfg_stamped && seen |-> rpt_stamp >= last;
  endproperty
  property p_share;
    rpt_valid && cfg_stamped && seen && age < WIN |-> rpt_stamp == last;
  endproperty
  property p_distinct;
    rpt_valid && cfg_stamped && seen && age >= WIN |-> rpt_stamp != last;
  endproperty
  property p_one; $onehot0(cfg_change_en); endproperty
  property p_new; rpt_valid |-> rpt_state != $past(rpt_state); endproperty
  a_ready: assert property (p_ready)
    else $error("Link not ready after reset.");
  a_gap: assert property (p_gap)
    else $error("Schedules too close.");
  a_hold: assert property (p_hold)
    else $error("Report changed without valid.");
  a_zero: assert property (p_zero)
    else $error("Stamp in plain format.");
  a_mono: assert property (p_mono)
    else $error("Stamp went back.");
  a_share: assert property (p_share)
    else $error("Stamp not shared in window.");
  a_distinct: assert property (p_distinct)
    else $error("Stamp reused after window.");
  a_one: assert property (p_one)
    else $error("Several points enabled.");
  a_new: assert property (p_new)
    else $error("Report without change.");
  c_rpt: cover property (rpt_valid && cfg_stamped);
  c_sch: cover property (sch_valid && sch_ready);
  c_share: cover property (rpt_valid && seen && age < WIN);
endmodule

// ===== sim/tb.sv
/* Bench joining both ends over the link.
   Assumes a 50 MHz clock and a short stamp window. */
`timescale 1ns/1ps
module tb;
  import cts_pkg::*;
  localparam int WIN = 50;
  logic  ref_clk, rst, master_valid, want_stamped, req_valid;
  logic  req_refused, got_valid, seen;
  logic  [3:0] seq_point;
  logic  [1:0] req_slot;
  pts_t  in_pins, out_pins, req_mask, req_value, got_state;
  time_t master_time, req_time, got_stamp, local_time, t0, s1;
  int    miscompares = 0;
  int    check_count = 0;
  cts_if cts_if_i ();
  cts_module_end #(.WIN_CYC(WIN)) cts_module_end_i (.ref_clk(ref_clk),
    .rst(rst), .lnk(cts_if_i.module_end), .in_pins(in_pins),
    .out_pins(out_pins), .local_time(local_time));
  cts_ctrl_end cts_ctrl_end_i (.ref_clk(ref_clk), .rst(rst),
    .lnk(cts_if_i.ctrl_end), .master_valid(master_valid),
    .master_time(master_time), .want_stamped(want_stamped),
    .seq_point(seq_point), .req_valid(req_valid), .req_slot(req_slot),
    .req_mask(req_mask), .req_value(req_value), .req_time(req_time),
    .req_refused(req_refused), .got_valid(got_valid),
    .got_state(got_state), .got_stamp(got_stamp));
  cts_assertions #(.WIN(WIN)) cts_assertions_i (.ref_clk(ref_clk),
    .rst(rst), .rpt_valid(cts_if_i.rpt_valid),
    .rpt_state(cts_if_i.rpt_state), .rpt_stamp(cts_if_i.rpt_stamp),
    .cfg_stamped(cts_if_i.cfg_stamped),
    .cfg_change_en(cts_if_i.cfg_change_en),
    .sch_valid(cts_if_i.sch_valid), .sch_ready(cts_if_i.sch_ready));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input time_t exp, got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic wait_got();
    for (int i = 0; i < 20 && got_valid !== 1'b1; i++) step(1);
    if (got_valid !== 1'b1) begin
      check("report", 64'h1, 64'h0);
      finish_test();
    end
  endtask
  task automatic t_stamp();
    in_pins[0] = 1'b1;
    wait_got();
    check("state", 64'h1, {48'h0, got_state});
    check("stamped", 64'h1, {63'h0, got_stamp !== 64'h0});
    s1 = got_stamp;
    step(2);
    in_pins[0] = 1'b0;
    wait_got();
    check("shared", s1, got_stamp);
    step(WIN + 20);
    in_pins[0] = 1'b1;
    wait_got();
    check("distinct", 64'h1, {63'h0, got_stamp >= s1 + WIN * 20});
    s1 = got_stamp;
    step(WIN - 5);
    in_pins[0] = 1'b0;
    wait_got();
    check("edge distinct", s1 + 64'(WIN * 20), got_stamp);
    s1 = got_stamp;
    step(WIN - 6);
    in_pins[0] = 1'b1;
    wait_got();
    check("edge shared", s1, got_stamp);
  endtask
  task automatic t_plain();
    want_stamped = 1'b0;
    step(WIN + 10);
    in_pins[0] = 1'b0;
    wait_got();
    check("plain stamp", 64'h0, got_stamp);
  endtask
  task automatic t_sync();
    t0 = local_time + 64'h0000_0000_0010_0000;
    master_time = t0;
    master_valid = 1'b1;
    step(1);
    master_valid = 1'b0;
    step(5);
    check("time jump", 64'h1, {63'h0, local_time >= t0});
  endtask
  task automatic t_sched();
    t0 = local_time + 64'd2000;
    req_slot = 2'h0;
    req_mask = 16'h0001;
    req_value = 16'h0001;
    req_time = t0;
    req_valid = 1'b1;
    step(2);
    req_valid = 1'b0;
    step(98);
    check("early", 64'h0, {63'h0, out_pins[0]});
    step(1);
    check("fired", 64'h1, {63'h0, out_pins[0]});
  endtask
  task automatic t_spread();
    seen = 1'b0;
    req_slot = 2'h1;
    req_mask = 16'h0002;
    req_time = local_time + 64'd1000000;
    req_valid = 1'b1;
    step(2);
    req_slot = 2'h2;
    req_time = req_time + SPREAD_TICKS + 64'd20;
    for (int i = 0; i < 8; i++) begin
      step(1);
      seen = seen | (req_refused === 1'b1);
    end
    req_valid = 1'b0;
    check("refused", 64'h1, {63'h0, seen});
  endtask
  initial begin
    rst = 1'b1;
    master_valid = 1'b0;
    master_time = '0;
    want_stamped = 1'b1;
    seq_point = 4'h0;
    req_valid = 1'b0;
    req_slot = 2'h0;
    req_mask = '0;
    req_value = '0;
    req_time = '0;
    in_pins = '0;
    repeat (4) @(posedge ref_clk);
    #2 rst = 1'b0;
    step(6);
    t_stamp();
    t_plain();
    t_sync();
    t_sched();
    t_spread();
    finish_test();
  end
endmodule
